// ===== rtl/ivw_consts.svh
// Constants of the interrupt vector and watchdog time-out block.
// Assumes inclusion by bare name from the rtl folder.
`ifndef IVW_CONSTS_SVH
`define IVW_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define IVW_OFS_CTRL    8'h00
`define IVW_OFS_CAUSE   8'h04
`define IVW_OFS_STAT    8'h08
`define IVW_OFS_MASK    8'h0c

// ----------------------------------------------------------------
// Dog control register fields
// ----------------------------------------------------------------
`define IVW_CT_FLAG     7
`define IVW_CT_IE       6
`define IVW_CT_TS3      5
`define IVW_CT_UNLOCK   4
`define IVW_CT_EN       3
`define IVW_CT_TS2      2
`define IVW_CT_TS0      0

// ----------------------------------------------------------------
// Reset cause register fields
// ----------------------------------------------------------------
`define IVW_RC_DOG      3
`define IVW_RC_BROWN    2
`define IVW_RC_EXT      1
`define IVW_RC_POWER    0

// ----------------------------------------------------------------
// Source bit positions; vector address is position plus one
// ----------------------------------------------------------------
`define IVW_SRC_EXT0    4'h0
`define IVW_SRC_PCA     4'h1
`define IVW_SRC_PCB     4'h2
`define IVW_SRC_DOG     4'h3
`define IVW_SRC_T16CAP  4'h4
`define IVW_SRC_T16OVF  4'h7
`define IVW_SRC_T8CMPA  4'h8
`define IVW_SRC_T8OVF   4'ha
`define IVW_SRC_SEROVF  4'hf
`define IVW_RESET_VEC   16'h0000
`define IVW_VEC_STEP    16'h0001

// ----------------------------------------------------------------
// Time-out select and unlock window
// ----------------------------------------------------------------
`define IVW_TS_LAST     4'h9
`define IVW_TS_RESET    4'h0
`define IVW_UNLOCK_CYC  3'h4
`define IVW_BASE_CYC    2048

`endif

// ===== rtl/ivw_pkg.sv
// Types shared by the interrupt vector and watchdog block.
// Assumes the constants header supplies all numbers.
package ivw_pkg;

    // ------------------------------------------------------------
    // Watchdog running mode
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ivw_dog_stopped,
        ivw_dog_irq,
        ivw_dog_irq_then_reset,
        ivw_dog_reset
    } ivw_dog_mode_t;

endpackage

// ===== rtl/ivw_prio.sv
// Lowest-index priority picker over a request vector.
// Assumes requests come from logic on the same clock.
`timescale 1ns/1ps

module ivw_prio
#(
    parameter int N = 16
)
(
    // Requests
    input  wire logic [N-1:0]         req_in,
    // Choice
    output logic      [$clog2(N)-1:0] idx_out,
    output logic                      valid_out
);

    initial
    begin
        if (N < 2)
            $error("ivw_prio needs at least two requests.");
    end

    always_comb
    begin
        idx_out   = '0;
        valid_out = 1'b0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (req_in[i])
            begin
                idx_out   = i[$clog2(N)-1:0];
                valid_out = 1'b1;
            end
        end
    end

endmodule

// ===== rtl/ivw_top.sv
// Interrupt vector dispatch and watchdog time-out with APB registers.
// Assumes an APB master on mclk_in and a slow watchdog oscillator pin.
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "ivw_consts.svh"

module ivw_top
#(
    parameter int BASE_CYC = `IVW_BASE_CYC,
    parameter int CNT_W    = 21
)
(
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        sys_rst_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Sources and reset causes, one-cycle pulses
    input  wire logic [15:0] src_in,
    input  wire logic        ext_rst_in,
    input  wire logic        por_in,
    input  wire logic        bor_in,
    // Core side
    input  wire logic        dog_kick_in,
    input  wire logic        vec_ack_in,
    output logic             vec_valid_out,
    output logic      [15:0] vec_addr_out,
    output logic             dog_reset_out,
    output logic             irq_out,
    // Watchdog oscillator pin
    input  wire logic        dog_osc_in
);

    initial
    begin
        if (CNT_W < 2 || BASE_CYC < 1 ||
            (longint'(BASE_CYC) << `IVW_TS_LAST) >= (longint'(1) << CNT_W))
            $error("ivw_top counter too narrow for the time-out.");
    end

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [CNT_W-1:0] ts_cycles(input logic [3:0] s);
        logic [3:0] c;
        c = (s > `IVW_TS_LAST) ? `IVW_TS_LAST : s;
        return CNT_W'(longint'(BASE_CYC) << c);
    endfunction

    function automatic logic [15:0] w1c(input logic [15:0] cur,
                                        input logic [15:0] set,
                                        input logic [15:0] clr);
        return (cur & ~clr) | set;
    endfunction

    // ------------------------------------------------------------
    // Registers and nets
    // ------------------------------------------------------------
    logic [3:0]       ts;
    logic             en_q;
    logic             ie;
    logic             unlock;
    logic [2:0]       unlock_cnt;
    logic [3:0]       cause;
    logic [15:0]      stat;
    logic [15:0]      mask;
    logic [CNT_W-1:0] cnt;
    logic             osc_s1;
    logic             osc_s2;
    logic             osc_s3;
    logic             osc_lvl;
    logic             osc_tick;
    logic             en_eff;
    logic             acc;
    logic             wr;
    logic             rd;
    logic             hit;
    logic [31:0]      rdata;
    logic             timeout;
    logic             dog_irq_ev;
    logic             dog_rst_ev;
    logic             any_rst;
    logic [15:0]      set_v;
    logic [15:0]      clr_v;
    logic [15:0]      pend;
    logic [3:0]       pick;
    logic             pick_v;
    logic [3:0]       next_ts;
    logic             wr_ctrl;
    ivw_pkg::ivw_dog_mode_t mode;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign acc     = psel_in & penable_in & pready_out;
    assign wr      = acc & pwrite_in;
    assign rd      = psel_in & penable_in & ~pready_out & ~pwrite_in;
    assign wr_ctrl = wr & (paddr_in == `IVW_OFS_CTRL);
    assign en_eff  = en_q | cause[`IVW_RC_DOG];

    always_comb
    begin
        hit   = 1'b1;
        rdata = 32'h0000_0000;
        unique case (paddr_in)
            `IVW_OFS_CTRL:
            begin
                rdata[`IVW_CT_FLAG]   = stat[`IVW_SRC_DOG];
                rdata[`IVW_CT_IE]     = ie;
                rdata[`IVW_CT_TS3]    = ts[3];
                rdata[`IVW_CT_UNLOCK] = unlock;
                rdata[`IVW_CT_EN]     = en_eff;
                rdata[`IVW_CT_TS2:`IVW_CT_TS0] = ts[2:0];
            end
            `IVW_OFS_CAUSE: rdata[3:0]  = cause;
            `IVW_OFS_STAT:  rdata[15:0] = stat;
            `IVW_OFS_MASK:  rdata[15:0] = mask;
            default:        hit = 1'b0;
        endcase
    end

    // One wait state: pready rises in the second access cycle.
    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end
        else
        begin
            pready_out  <= psel_in & penable_in & ~pready_out;
            pslverr_out <= psel_in & penable_in & ~pready_out & ~hit;
            if (rd)
                prdata_out <= rdata;
        end
    end

    // ------------------------------------------------------------
    // Watchdog oscillator synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            osc_s1  <= 1'b0;
            osc_s2  <= 1'b0;
            osc_s3  <= 1'b0;
            osc_lvl <= 1'b0;
        end
        else
        begin
            osc_s1 <= dog_osc_in;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
            if (osc_s2 == osc_s3)
                osc_lvl <= osc_s3;
        end
    end

    assign osc_tick = (osc_s2 == osc_s3) & osc_s3 & ~osc_lvl;

    // ------------------------------------------------------------
    // Watchdog mode and counter
    // ------------------------------------------------------------
    always_comb
    begin
        unique case ({en_eff, ie})
            2'b00:   mode = ivw_pkg::ivw_dog_stopped;
            2'b01:   mode = ivw_pkg::ivw_dog_irq;
            2'b11:   mode = ivw_pkg::ivw_dog_irq_then_reset;
            2'b10:   mode = ivw_pkg::ivw_dog_reset;
        endcase
    end

    assign timeout    = osc_tick & (mode != ivw_pkg::ivw_dog_stopped) &
                        (cnt >= ts_cycles(ts) - CNT_W'(1));
    assign dog_irq_ev = timeout & ie;
    assign dog_rst_ev = timeout & ~ie;

    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            cnt <= '0;
        else if (dog_kick_in || timeout ||
                 mode == ivw_pkg::ivw_dog_stopped)
            cnt <= '0;
        else if (osc_tick)
            cnt <= cnt + CNT_W'(1);
    end

    // ------------------------------------------------------------
    // Dog control register and unlock window
    // ------------------------------------------------------------
    always_comb
    begin
        next_ts = ts;
        if (unlock)
            next_ts = {pwdata_in[`IVW_CT_TS3],
                       pwdata_in[`IVW_CT_TS2:`IVW_CT_TS0]};
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            unlock     <= 1'b0;
            unlock_cnt <= 3'h0;
        end
        else if (wr_ctrl && pwdata_in[`IVW_CT_UNLOCK] &&
                 pwdata_in[`IVW_CT_EN])
        begin
            unlock     <= 1'b1;
            unlock_cnt <= `IVW_UNLOCK_CYC;
        end
        else if (unlock_cnt == 3'h1)
        begin
            unlock     <= 1'b0;
            unlock_cnt <= 3'h0;
        end
        else if (unlock_cnt != 3'h0)
            unlock_cnt <= unlock_cnt - 3'h1;
    end

    // The select only moves inside the window, so an unlocking write
    // that carries a stray select cannot shorten the time-out.
    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            ts <= `IVW_TS_RESET;
        else if (wr_ctrl && !pwdata_in[`IVW_CT_UNLOCK])
            ts <= next_ts;
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            en_q <= 1'b0;
        else if (wr_ctrl && pwdata_in[`IVW_CT_EN])
            en_q <= 1'b1;
        else if (wr_ctrl && unlock && !cause[`IVW_RC_DOG])
            en_q <= 1'b0;
    end

    // Hardware drops the interrupt enable on a time-out with reset
    // armed, so the next time-out resets unless software re-arms.
    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            ie <= 1'b0;
        else if (dog_irq_ev && en_eff)
            ie <= 1'b0;
        else if (wr_ctrl)
            ie <= pwdata_in[`IVW_CT_IE];
    end

    // ------------------------------------------------------------
    // Reset cause flags: hardware set wins over a written zero
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            cause <= 4'h0;
        else
        begin
            if (wr && paddr_in == `IVW_OFS_CAUSE)
                cause <= cause & pwdata_in[3:0];
            if (dog_rst_ev)
                cause[`IVW_RC_DOG] <= 1'b1;
            if (bor_in)
                cause[`IVW_RC_BROWN] <= 1'b1;
            if (ext_rst_in)
                cause[`IVW_RC_EXT] <= 1'b1;
            if (por_in)
                cause[`IVW_RC_POWER] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, mask and dispatch
    // ------------------------------------------------------------
    always_comb
    begin
        set_v = src_in;
        set_v[`IVW_SRC_DOG] = dog_irq_ev;
        clr_v = 16'h0000;
        if (wr && paddr_in == `IVW_OFS_STAT)
            clr_v = pwdata_in[15:0];
        if (wr_ctrl && pwdata_in[`IVW_CT_FLAG])
            clr_v[`IVW_SRC_DOG] = 1'b1;
        if (vec_ack_in && vec_valid_out)
            clr_v[pick] = 1'b1;
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            stat <= 16'h0000;
        else
            stat <= w1c(stat, set_v, clr_v);
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            mask <= 16'h0000;
        else if (wr && paddr_in == `IVW_OFS_MASK)
            mask <= pwdata_in[15:0];
    end

    // Masked sources never dispatch, so their slots stay plain code.
    assign pend = stat & mask;

    ivw_prio
    #(
        .N (16)
    )
    u_prio
    (
        .req_in    (pend),
        .idx_out   (pick),
        .valid_out (pick_v)
    );

    assign any_rst = dog_rst_ev | ext_rst_in | por_in | bor_in;

    // Vector address is the source position plus one: bit 0 is
    // external request zero, bits 1..2 the pin-change groups, bit 3
    // the dog time-out, bits 4..7 the 16-bit timer, bits 8..10 the
    // 8-bit timer, then comparator, converter, eeprom and serial.
    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            vec_valid_out <= 1'b0;
            vec_addr_out  <= `IVW_RESET_VEC;
        end
        else if (any_rst)
        begin
            vec_valid_out <= 1'b0;
            vec_addr_out  <= `IVW_RESET_VEC;
        end
        else
        begin
            vec_valid_out <= pick_v & ~(vec_ack_in & vec_valid_out);
            vec_addr_out  <= {12'h000, pick} + `IVW_VEC_STEP;
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            dog_reset_out <= 1'b0;
            irq_out       <= 1'b0;
        end
        else
        begin
            dog_reset_out <= dog_rst_ev;
            // The written mask is used so the line tracks a mask write.
            irq_out       <= |(w1c(stat, set_v, clr_v) &
                               ((wr && paddr_in == `IVW_OFS_MASK) ?
                                pwdata_in[15:0] : mask));
        end
    end

endmodule

// ===== rtl/ivw_placeholder_unused.sv
`timescale 1ns/1ps
// Intentionally empty.

// ===== tb/ivw_properties.sv
// Port checker of the vector dispatch and watchdog block.
// Assumes binding to ivw_top, one clock and an async high reset.
`timescale 1ns/1ps

module ivw_properties
(
    // Clock and reset
    input wire logic        mclk_in,
    input wire logic        sys_rst_in,
    // APB slave
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    // Reset causes and core side
    input wire logic        ext_rst_in,
    input wire logic        por_in,
    input wire logic        bor_in,
    input wire logic        vec_valid_out,
    input wire logic [15:0] vec_addr_out,
    input wire logic        dog_reset_out,
    input wire logic        irq_out
);
    // ------------------------------------------------------------
    // Shared timing
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);
    sequence s_setup;
        psel_in && !penable_in;
    endsequence
    sequence s_wait;
        psel_in && penable_in && !pready_out;
    endsequence
    logic bad;
    assign bad = (paddr_in > 8'h0c) || (paddr_in[1:0] != 2'h0);

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_ready_one_wait: assert property (s_setup ##1 s_wait |=> pready_out)
        else $error("ready not in second access cycle");
    a_ready_in_access: assert property (pready_out |-> psel_in && penable_in)
        else $error("ready outside an access");
    a_ready_one_cycle: assert property (pready_out |=> !pready_out)
        else $error("ready longer than one cycle");
    a_err_decode: assert property (pready_out |-> pslverr_out == bad)
        else $error("error flag does not match decode");
    a_err_zero_data: assert property
        (pready_out && pslverr_out && !pwrite_in |-> prdata_out == 32'h0)
        else $error("refused read returns data");
    a_cause_vector: assert property
        (ext_rst_in || por_in || bor_in |=> vec_addr_out == 16'h0000)
        else $error("reset cause did not select the reset vector");
    a_dog_vector: assert property
        (dog_reset_out |-> ##[0:1] vec_addr_out == 16'h0000)
        else $error("dog reset did not select the reset vector");
    a_dog_one_pulse: assert property (dog_reset_out |=> !dog_reset_out)
        else $error("dog reset longer than one cycle");
    a_vec_in_table: assert property
        (vec_valid_out |-> vec_addr_out inside {[16'h0001:16'h0010]})
        else $error("presented vector outside the table");
    a_vec_after_irq: assert property
        ($rose(vec_valid_out) |-> $past(irq_out))
        else $error("vector presented without an unmasked request");
endmodule

bind ivw_top ivw_properties chk_u
(
    .mclk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .prdata_out, .pready_out, .pslverr_out, .ext_rst_in, .por_in, .bor_in,
    .vec_valid_out, .vec_addr_out, .dog_reset_out, .irq_out
);

// ===== tb/ivw_top_tb.sv
// Self-checking bench of the vector dispatch and watchdog block.
// Assumes the bound checker and a time-out base cut down to four.
`timescale 1ns/1ps
`include "ivw_consts.svh"

module ivw_top_tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int BASE = 4;
    localparam int OSC  = 5;
    logic        mclk_in = 1'b0, sys_rst_in = 1'b1, dog_osc_in = 1'b0;
    logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [7:0]  paddr_in = 8'h0;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
    logic        pready_out, pslverr_out, err;
    logic [15:0] src_in = 16'h0, vec_addr_out, v;
    logic        ext_rst_in = 1'b0, por_in = 1'b0, bor_in = 1'b0;
    logic        dog_kick_in = 1'b0, vec_ack_in = 1'b0;
    logic        vec_valid_out, dog_reset_out, irq_out;
    int          mismatches = 0, tests_run = 0;

    always #10 mclk_in = ~mclk_in;
    // The oscillator is offset so its edges never meet the core clock.
    initial
    begin
        #3;
        forever #50 dog_osc_in = ~dog_osc_in;
    end

    ivw_top #(.BASE_CYC(BASE), .CNT_W(21)) dut_u
    (
        .mclk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in,
        .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
        .src_in, .ext_rst_in, .por_in, .bor_in, .dog_kick_in,
        .vec_ack_in, .vec_valid_out, .vec_addr_out, .dog_reset_out,
        .irq_out, .dog_osc_in
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Keeping psel up lets a following transfer start without idle.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic bk);
        int n;
        n = 0;
        psel_in   <= 1'b1;
        pwrite_in <= w;
        paddr_in  <= a;
        pwdata_in <= d;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        do
        begin
            @(posedge mclk_in);
            n++;
        end
        while (pready_out !== 1'b1 && n < 20);
        if (n >= 20)
            mismatches++;
        rd  = prdata_out;
        err = pslverr_out;
        penable_in <= 1'b0;
        if (!bk)
        begin
            psel_in <= 1'b0;
            @(posedge mclk_in);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 1'b0);
        chk(rd, e);
    endtask

    task automatic pulse(input logic [15:0] s);
        src_in <= s;
        @(posedge mclk_in);
        src_in <= 16'h0;
        @(posedge mclk_in);
    endtask

    task automatic take(input logic [15:0] e);
        int n;
        n = 0;
        while (!(vec_valid_out === 1'b1 && vec_addr_out === e) && n < 40)
        begin
            @(posedge mclk_in);
            n++;
        end
        chk({16'h0, vec_addr_out}, {16'h0, e});
        chk({31'h0, irq_out}, 32'h1);
        vec_ack_in <= 1'b1;
        @(posedge mclk_in);
        vec_ack_in <= 1'b0;
        @(posedge mclk_in);
    endtask

    task automatic kick();
        dog_kick_in <= 1'b1;
        @(posedge mclk_in);
        dog_kick_in <= 1'b0;
    endtask

    task automatic tmo(input int edges);
        int n;
        int e;
        n = 0;
        e = edges * OSC;
        kick();
        while (dog_reset_out !== 1'b1 && n < 12000)
        begin
            @(posedge mclk_in);
            n++;
        end
        chk({31'h0, n >= e - 6 && n <= e + 10}, 32'h1);
    endtask

    // The kick keeps a short time-out from landing inside the sequence.
    task automatic seq(input logic clr, input logic [31:0] s,
                       input logic [31:0] d, input int gap);
        kick();
        if (clr)
            apb(1'b1, `IVW_OFS_CAUSE, 32'h0, 1'b1);
        apb(1'b1, `IVW_OFS_CTRL, 32'h18 | s, gap == 0);
        repeat (gap) @(posedge mclk_in);
        wr(`IVW_OFS_CTRL, d);
    endtask

    function automatic logic [31:0] sb(input logic [3:0] s);
        return {26'h0, s[3], 2'h0, s[2:0]};
    endfunction

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        #1_000_000;
        mismatches++;
        conclude();
    end

    initial
    begin
        void'($urandom(32'hac8f));
        repeat (20) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        @(posedge mclk_in);
        for (int i = 0; i < 4; i++)
            rdc(8'(i * 4), 32'h0);
        apb(1'b0, 8'h10, 32'h0, 1'b0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, 8'h02, 32'h5, 1'b0);
        chk({31'h0, err}, 32'h1);
        wr(`IVW_OFS_MASK, 32'hfffe);
        pulse(16'h0001);
        repeat (4) @(posedge mclk_in);
        chk({31'h0, vec_valid_out | irq_out}, 32'h0);
        rdc(`IVW_OFS_STAT, 32'h1);
        wr(`IVW_OFS_STAT, 32'h1);
        rdc(`IVW_OFS_STAT, 32'h0);
        wr(`IVW_OFS_MASK, 32'hffff);
        for (int k = 0; k < 22; k++)
        begin
            v = (k < 16) ? 16'h1 << k : 16'($urandom);
            v = v & 16'hfff7;
            if (v != 16'h0)
            begin
                pulse(v);
                for (int i = 0; i < 16; i++)
                    if (v[i])
                        take(16'(i + 1));
            end
        end
        repeat (3) @(posedge mclk_in);
        chk({31'h0, irq_out}, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            {bor_in, ext_rst_in, por_in} <= 3'h1 << i;
            @(posedge mclk_in);
            {bor_in, ext_rst_in, por_in} <= 3'h0;
            @(posedge mclk_in);
            chk({16'h0, vec_addr_out}, 32'h0);
        end
        rdc(`IVW_OFS_CAUSE, 32'h7);
        wr(`IVW_OFS_CAUSE, 32'h0);
        wr(`IVW_OFS_CTRL, 32'h40);
        take(16'h0004);
        wr(`IVW_OFS_CTRL, 32'h80);
        wr(`IVW_OFS_STAT, 32'hffff);
        wr(`IVW_OFS_CTRL, 32'h08);
        tmo(BASE);
        rdc(`IVW_OFS_CAUSE, 32'h8);
        seq(1'b0, 32'h0, 32'h0, 0);
        rdc(`IVW_OFS_CTRL, 32'h08);
        seq(1'b1, 32'h0, sb(4'h1) | 32'h08, 0);
        tmo(BASE << 1);
        seq(1'b1, sb(4'h1), sb(4'hc) | 32'h08, 0);
        tmo(BASE << 9);
        seq(1'b1, sb(4'hc), 32'h0, 6);
        rdc(`IVW_OFS_CTRL, sb(4'hc) | 32'h08);
        seq(1'b1, sb(4'hc), 32'h0, 0);
        rdc(`IVW_OFS_CTRL, 32'h0);
        wr(`IVW_OFS_CTRL, 32'h48);
        take(16'h0004);
        rdc(`IVW_OFS_CTRL, 32'h08);
        tmo(BASE);
        conclude();
    end
endmodule
